//--- rtl/srer_pkg.sv
package srer_pkg;

  // Command codes decoded by the interpreter, and the queued error log address
  localparam logic [7:0] CMD_SENSE_REQ = 8'h0B;
  localparam logic [7:0] CMD_ELEM_REMOVE = 8'h7C;
  localparam logic [7:0] CMD_ELEM_RESTORE = 8'h7D;
  localparam logic [7:0] CMD_LOG_READ_PIO = 8'h2F;
  localparam logic [7:0] CMD_LOG_READ_DMA = 8'h47;
  localparam logic [7:0] LOG_QUEUED_ERR = 8'h10;

  // Output field bit positions
  localparam int ERR_ABORT_BIT = 2;
  localparam int STS_SENSE_BIT = 1;
  localparam int STS_ERROR_BIT = 0;
  localparam int LBA_DEFER_BIT = 20;
  localparam int LBA_KEY_LSB = 16;
  localparam int LBA_ASC_LSB = 8;
  localparam int LBA_BEFORE_HI_LSB = 32;

  // Sense codes: {key, additional code, qualifier}
  localparam logic [19:0] SENSE_NONE = 20'h0_00_00;
  localparam logic [19:0] SENSE_UCODE_ACT_REQ = 20'h2_04_26;
  localparam logic [19:0] SENSE_CMD_SEQ_ERR = 20'h5_2C_00;
  localparam logic [19:0] SENSE_BAD_FIELD = 20'h5_24_00;
  localparam logic [19:0] SENSE_BAD_OPCODE = 20'h5_20_00;

  // Register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ELEM_DEPOP = 8'h04;
  localparam logic [7:0] REG_ELEM_ALLOW = 8'h08;
  localparam logic [7:0] REG_SENSE = 8'h0C;
  localparam logic [7:0] REG_INT_STS = 8'h10;
  localparam logic [7:0] REG_INT_MASK = 8'h14;

  // Field positions
  localparam int CTRL_FW_PEND_BIT = 0;
  localparam int SENSE_VALID_BIT = 24;
  localparam int INT_DONE_BIT = 0;
  localparam int INT_ERR_BIT = 1;
  localparam int INT_SENSE_BIT = 2;

  // Reset values
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [2:0] INT_MASK_RESET = 3'h0;

endpackage

//--- rtl/srer_elem_if.sv
`timescale 1ns/10ps
`default_nettype none
interface srer_elem_if #(parameter int NUM_ELEM = 8);
  logic load_depop;
  logic load_allow;
  logic [NUM_ELEM-1:0] load_data;
  logic restore_go;
  logic remove_go;
  logic [15:0] remove_idx;
  logic [NUM_ELEM-1:0] depop;
  logic [NUM_ELEM-1:0] allow;
  logic [31:0] count_before;
  logic [31:0] count_after;
  logic restore_ok;
  logic idx_ok;
  modport ctrl (output load_depop, load_allow, load_data, restore_go, remove_go, remove_idx,
    input depop, allow, count_before, count_after, restore_ok, idx_ok);
  modport elem (input load_depop, load_allow, load_data, restore_go, remove_go, remove_idx,
    output depop, allow, count_before, count_after, restore_ok, idx_ok);
endinterface
`default_nettype wire

//--- rtl/srer_elem_map.sv
`timescale 1ns/10ps
`default_nettype none
module srer_elem_map #(
  parameter int NUM_ELEM = 8
) (
  input wire logic clk, // 20 MHz clock
  input wire logic reset, // Asynchronous, active high
  srer_elem_if.elem bus // Element map controls and results
);

  logic [NUM_ELEM-1:0] depop;
  logic [NUM_ELEM-1:0] allow;
  logic [NUM_ELEM-1:0] remain;
  logic [NUM_ELEM-1:0] idx_hot;
  logic [31:0] cnt_before;
  logic [31:0] cnt_after;

  // Per element: what stays depopulated after a restore, and removal select
  genvar g;
  generate
    for (g = 0; g < NUM_ELEM; g = g + 1) begin : g_elem
      assign remain[g] = depop[g] & ~allow[g];
      assign idx_hot[g] = (bus.remove_idx == 16'(g));
    end
  endgenerate

  always_comb begin
    cnt_before = 32'h0000_0000;
    cnt_after = 32'h0000_0000;
    for (int i = 0; i < NUM_ELEM; i++) begin
      cnt_before = cnt_before + {31'h0000_0000, depop[i]};
      cnt_after = cnt_after + {31'h0000_0000, remain[i]};
    end
  end

  assign bus.depop = depop;
  assign bus.allow = allow;
  assign bus.count_before = cnt_before;
  assign bus.count_after = cnt_after;
  assign bus.restore_ok = (depop == '0) || ((depop & allow) != '0); // R13 R15
  assign bus.idx_ok = |idx_hot;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      depop <= '0;
    end else if (bus.load_depop) begin
      depop <= bus.load_data;
    end else if (bus.restore_go && bus.restore_ok) begin
      depop <= remain; // R12
    end else if (bus.remove_go) begin
      depop <= depop | idx_hot;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      allow <= '0;
    end else if (bus.load_allow) begin
      allow <= bus.load_data;
    end
  end

endmodule // srer_elem_map
`default_nettype wire

//--- rtl/srer_cmd_core.sv
// Notes on behaviour
// (R1) Removal command aborts with microcode-activation sense while activation is pending.
// (R2) Completion with sense-available set always has a sense code stored.
// (R3) One sense record; every new event overwrites it.
// (R4) Sense discarded on reset, on other accepted commands, after sense request.
// (R5) Sense reporting is on from reset, no enabling command needed.
// (R6) Code 0Bh is the sense request; its input fields are ignored.
// (R7) Sense request returns deferred bit 20, key 19:16, code 15:8, qualifier 7:0.
// (R8) Sense from an errored completion is current: deferred bit clear.
// (R9) Sense from posted events without failing command is deferred: bit set.
// (R10) Sense request status: bit 1 sense available, bit 0 error, bits 5:2 zero.
// (R11) Code 7Dh is the restore command; its input fields are ignored.
// (R12) Restore brings back depopulated elements whose restoration is allowed.
// (R13) Restore succeeds if none depopulated or at least one depopulated element is allowed.
// (R14) Restore returns before count in COUNT and LBA 47:32, after count LBA 31:0.
// (R15) Restore fails with command-sequence sense when no depopulated element is allowed.
// (R16) Restore aborts with microcode-activation sense while activation is pending.
// (R17) Aborts set error bit 2 and status bit 0 and store matching sense.
// (R18) Sense-available follows the stored record: set on store, clear on discard.
//
// The address-and-strobe port and the register addresses were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module srer_cmd_core #(
  parameter int NUM_ELEM = 8
) (
  input wire logic clk, // 20 MHz clock
  input wire logic reset, // Asynchronous, active high
  input wire logic cmd_valid, // One-cycle command strobe
  input wire logic [7:0] cmd_code, // Command code
  input wire logic [15:0] cmd_feature, // Feature field
  input wire logic [15:0] cmd_count, // Count field
  input wire logic [47:0] cmd_lba, // LBA field
  output logic done, // One-cycle completion pulse
  output logic [7:0] out_error, // Error output field
  output logic [15:0] out_count, // Count output field
  output logic [47:0] out_lba, // LBA output field
  output logic [7:0] out_status, // Status output field
  output logic sense_avail, // Stored sense record is valid
  input wire logic [7:0] reg_addr, // Register byte address
  input wire logic [31:0] reg_wdata, // Register write data
  input wire logic reg_wr, // Register write strobe
  input wire logic reg_rd, // Register read strobe
  output logic [31:0] reg_rdata, // Read data, cycle after strobe
  output logic irq // Level interrupt
);

  ////////////////////////////////////////////////////////////////////////////
  // Element map

  srer_elem_if #(.NUM_ELEM(NUM_ELEM)) elem_bus ();

  srer_elem_map #(.NUM_ELEM(NUM_ELEM)) u_elem (
    .clk(clk),
    .reset(reset),
    .bus(elem_bus)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Register decode

  logic [31:0] ctrl;
  logic [2:0] int_sts;
  logic [2:0] int_mask;
  logic sense_valid;
  logic sense_defer;
  logic [19:0] sense_code;

  wire hit_ctrl = (reg_addr == srer_pkg::REG_CTRL);
  wire hit_depop = (reg_addr == srer_pkg::REG_ELEM_DEPOP);
  wire hit_allow = (reg_addr == srer_pkg::REG_ELEM_ALLOW);
  wire hit_sense = (reg_addr == srer_pkg::REG_SENSE);
  wire hit_ists = (reg_addr == srer_pkg::REG_INT_STS);
  wire hit_imask = (reg_addr == srer_pkg::REG_INT_MASK);
  wire wr_ctrl = reg_wr && hit_ctrl;
  wire wr_sense = reg_wr && hit_sense;
  wire wr_ists = reg_wr && hit_ists;
  wire wr_imask = reg_wr && hit_imask;
  wire fw_pending = ctrl[srer_pkg::CTRL_FW_PEND_BIT];

  logic [31:0] rd_mux;
  always_comb begin
    if (hit_ctrl) begin
      rd_mux = ctrl;
    end else if (hit_depop) begin
      rd_mux = 32'(elem_bus.depop);
    end else if (hit_allow) begin
      rd_mux = 32'(elem_bus.allow);
    end else if (hit_sense) begin
      rd_mux = {7'h00, sense_valid, 3'h0, sense_defer, sense_code};
    end else if (hit_ists) begin
      rd_mux = {29'h0000_0000, int_sts};
    end else if (hit_imask) begin
      rd_mux = {29'h0000_0000, int_mask};
    end else begin
      // Unmapped addresses read as zero
      rd_mux = 32'h0000_0000;
    end
  end

  assign elem_bus.load_depop = reg_wr && hit_depop;
  assign elem_bus.load_allow = reg_wr && hit_allow;
  assign elem_bus.load_data = reg_wdata[NUM_ELEM-1:0];

  ////////////////////////////////////////////////////////////////////////////
  // Command decode

  wire is_sense_req = (cmd_code == srer_pkg::CMD_SENSE_REQ); // R6
  wire is_restore = (cmd_code == srer_pkg::CMD_ELEM_RESTORE); // R11
  wire is_remove = (cmd_code == srer_pkg::CMD_ELEM_REMOVE);
  wire is_log_read = (cmd_code == srer_pkg::CMD_LOG_READ_PIO) ||
    (cmd_code == srer_pkg::CMD_LOG_READ_DMA);
  wire reads_err_log = is_log_read && (cmd_lba[7:0] == srer_pkg::LOG_QUEUED_ERR);
  wire is_known = is_sense_req || is_restore || is_remove || is_log_read;

  wire restore_go = cmd_valid && is_restore && !fw_pending;
  wire remove_go = cmd_valid && is_remove && !fw_pending && elem_bus.idx_ok;
  assign elem_bus.restore_go = restore_go;
  assign elem_bus.remove_go = remove_go;
  // Element identifier low half sits in the count field
  assign elem_bus.remove_idx = cmd_count;

  // Failure cause and its sense code
  logic fail;
  logic [19:0] fail_code;
  always_comb begin
    fail = 1'b0;
    fail_code = srer_pkg::SENSE_NONE;
    if (!is_known) begin
      fail = 1'b1;
      fail_code = srer_pkg::SENSE_BAD_OPCODE;
    end else if ((is_remove || is_restore) && fw_pending) begin
      fail = 1'b1; // R1 R16
      fail_code = srer_pkg::SENSE_UCODE_ACT_REQ; // R1 R16
    end else if (is_restore && !elem_bus.restore_ok) begin
      fail = 1'b1; // R15
      fail_code = srer_pkg::SENSE_CMD_SEQ_ERR; // R15
    end else if (is_remove && !elem_bus.idx_ok) begin
      fail = 1'b1;
      fail_code = srer_pkg::SENSE_BAD_FIELD;
    end
  end

  wire cmd_fail = cmd_valid && fail;
  // The queued error log read keeps the record so it can be fetched afterwards
  wire cmd_discard = cmd_valid && !reads_err_log; // R4
  wire post_event = wr_sense;

  ////////////////////////////////////////////////////////////////////////////
  // Sense record
  // Applied in order, each overriding the last: discard, then a posted event, then the
  // failing command itself, so a failing command wins over a posted event in the same cycle.

  logic next_valid;
  logic next_defer;
  logic [19:0] next_code;
  always_comb begin
    next_valid = sense_valid;
    next_defer = sense_defer;
    next_code = sense_code;
    if (cmd_discard) begin
      next_valid = 1'b0; // R4 R18
    end
    if (post_event) begin
      next_valid = 1'b1; // R3 R18
      next_defer = 1'b1; // R9
      next_code = reg_wdata[19:0]; // R3
    end
    if (cmd_fail) begin
      next_valid = 1'b1; // R17 R18
      next_defer = 1'b0; // R8
      next_code = fail_code; // R2 R17
    end
  end

  // Reporting needs no enable: the record works from reset onward
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sense_valid <= 1'b0; // R4 R5
      sense_defer <= 1'b0;
      sense_code <= srer_pkg::SENSE_NONE;
    end else begin
      sense_valid <= next_valid;
      sense_defer <= next_defer;
      sense_code <= next_code;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output fields

  logic [7:0] next_error;
  logic [15:0] next_count;
  logic [47:0] next_lba;
  logic [7:0] next_status;
  always_comb begin
    next_error = 8'h00;
    next_count = 16'h0000;
    next_lba = 48'h0000_0000_0000;
    next_status = 8'h00;
    if (cmd_fail) begin
      next_error[srer_pkg::ERR_ABORT_BIT] = 1'b1; // R17
      next_status[srer_pkg::STS_ERROR_BIT] = 1'b1; // R17
      next_status[srer_pkg::STS_SENSE_BIT] = 1'b1; // R2 R17
    end else if (is_sense_req) begin
      if (sense_valid) begin
        next_lba[srer_pkg::LBA_DEFER_BIT] = sense_defer; // R7
        next_lba[srer_pkg::LBA_KEY_LSB +: 4] = sense_code[19:16]; // R7
        next_lba[srer_pkg::LBA_ASC_LSB +: 8] = sense_code[15:8]; // R7
        next_lba[7:0] = sense_code[7:0]; // R7
      end
      next_status[srer_pkg::STS_SENSE_BIT] = sense_valid; // R10
    end else begin
      if (is_restore) begin
        next_count = elem_bus.count_before[15:0]; // R14
        next_lba[srer_pkg::LBA_BEFORE_HI_LSB +: 16] = elem_bus.count_before[31:16]; // R14
        next_lba[31:0] = elem_bus.count_after; // R14
      end
      next_status[srer_pkg::STS_SENSE_BIT] = next_valid; // R18
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      done <= 1'b0;
      out_error <= 8'h00;
      out_count <= 16'h0000;
      out_lba <= 48'h0000_0000_0000;
      out_status <= 8'h00;
    end else begin
      done <= cmd_valid;
      if (cmd_valid) begin
        out_error <= next_error;
        out_count <= next_count;
        out_lba <= next_lba;
        out_status <= next_status;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sense_avail <= 1'b0;
    end else begin
      sense_avail <= next_valid; // R18
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers and interrupt

  logic [2:0] int_set;
  assign int_set = {post_event || cmd_fail, cmd_fail, cmd_valid};

  // A set arriving with a write-one clear wins, so no event is lost
  wire [2:0] next_int_sts = (int_sts & ~(wr_ists ? reg_wdata[2:0] : 3'h0)) | int_set;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ctrl <= srer_pkg::CTRL_RESET;
      int_sts <= 3'h0;
      int_mask <= srer_pkg::INT_MASK_RESET;
    end else begin
      if (wr_ctrl) begin
        ctrl <= {31'h0000_0000, reg_wdata[srer_pkg::CTRL_FW_PEND_BIT]};
      end
      if (wr_imask) begin
        int_mask <= reg_wdata[2:0];
      end
      int_sts <= next_int_sts;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      reg_rdata <= 32'h0000_0000;
      irq <= 1'b0;
    end else begin
      reg_rdata <= reg_rd ? rd_mux : 32'h0000_0000;
      irq <= |(next_int_sts & int_mask);
    end
  end

endmodule // srer_cmd_core
`default_nettype wire

//--- sim/srer_cmd_props.sv
`timescale 1ns/10ps
`default_nettype none
module srer_cmd_props #(
  parameter int NUM_ELEM = 8
) (
  input wire logic clk, // Clock
  input wire logic reset, // Async reset
  input wire logic cmd_valid, // Command strobe
  input wire logic [7:0] cmd_code, // Command code
  input wire logic [15:0] cmd_feature, // Feature field
  input wire logic [15:0] cmd_count, // Count field
  input wire logic [47:0] cmd_lba, // LBA field
  input wire logic done, // Completion pulse
  input wire logic [7:0] out_error, // Error output
  input wire logic [15:0] out_count, // Count output
  input wire logic [47:0] out_lba, // LBA output
  input wire logic [7:0] out_status, // Status output
  input wire logic sense_avail, // Record valid
  input wire logic [7:0] reg_addr, // Register address
  input wire logic [31:0] reg_wdata, // Write data
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  input wire logic [31:0] reg_rdata, // Read data
  input wire logic irq // Interrupt
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  ////////////////////////////////////////////////////////////////////////////////
  logic fw_pend;
  wire set_fw = reg_wr && (reg_addr == srer_pkg::REG_CTRL);
  wire post = reg_wr && (reg_addr == srer_pkg::REG_SENSE);
  wire is_sense = cmd_valid && (cmd_code == srer_pkg::CMD_SENSE_REQ);
  // Shadow of the pending bit; commands racing its write are left unjudged
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      fw_pend <= 1'b0;
    end else if (set_fw) begin
      fw_pend <= reg_wdata[0];
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  done_pulse_a: assert property (cmd_valid |=> done ##1 ($past(cmd_valid) || !done))
    else $error("done not a one-cycle answer");
  sense_fields_a:
    assert property (is_sense |=> done && out_error == 8'h00 && out_status[5:0] == 6'h00 ||
      done && out_status[5:2] == 4'h0 && !out_status[0]) else $error("sense status bad");
  sense_drop_a:
    assert property (is_sense && !post |=> !sense_avail) else $error("record kept");
  fw_remove_a:
    assert property (cmd_valid && cmd_code == srer_pkg::CMD_ELEM_REMOVE && fw_pend && !set_fw
      |=> out_error == 8'h04 && out_status[0]) else $error("remove not aborted");
  fw_restore_a:
    assert property (cmd_valid && cmd_code == srer_pkg::CMD_ELEM_RESTORE && fw_pend && !set_fw
      |=> out_error == 8'h04 && out_status[0]) else $error("restore not aborted");
  abort_sense_a:
    assert property (done && out_error[2] |-> out_status[1:0] == 2'b11 && sense_avail)
      else $error("abort without sense");
  avail_mirror_a:
    assert property (done && $past(cmd_code) != srer_pkg::CMD_SENSE_REQ
      |-> out_status[1] == sense_avail) else $error("status bit 1 wrong");
  restore_count_a:
    assert property (done && $past(cmd_code) == srer_pkg::CMD_ELEM_RESTORE && out_error == 8'h00
      |-> out_lba[31:0] <= {out_lba[47:32], out_count}) else $error("after above before");
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside slot");
  restore_c: cover property (done && out_count != 16'h0);
  abort_c: cover property (done && out_error[2]);
  sense_c: cover property (is_sense && sense_avail);
endmodule // srer_cmd_props
bind srer_cmd_core srer_cmd_props #(.NUM_ELEM(NUM_ELEM)) u_props (.clk(clk), .reset(reset),
  .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_feature(cmd_feature), .cmd_count(cmd_count),
  .cmd_lba(cmd_lba), .done(done), .out_error(out_error), .out_count(out_count),
  .out_lba(out_lba), .out_status(out_status), .sense_avail(sense_avail), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));
`default_nettype wire

//--- sim/srer_host.sv
`timescale 1ns/10ps
`default_nettype none
module srer_host (
  input wire logic clk, // Clock
  output var logic cmd_valid, // Command strobe
  output var logic [7:0] cmd_code, // Command code
  output var logic [15:0] cmd_feature, // Feature field
  output var logic [15:0] cmd_count, // Element index
  output var logic [47:0] cmd_lba // LBA field
);
  initial begin
    cmd_valid = 1'b0;
    cmd_code = 8'h00;
    cmd_feature = 16'h0000;
    cmd_count = 16'h0000;
    cmd_lba = 48'h0;
  end
  task automatic issue(input logic [7:0] code, input logic [15:0] idx);
    logic log_rd;
    // For the two log reads the parameter is the log address, else the element index
    log_rd = (code == 8'h2F) || (code == 8'h47);
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_code <= code;
    cmd_feature <= 16'h0000;
    cmd_count <= log_rd ? 16'h0000 : idx;
    cmd_lba <= log_rd ? {32'h0000_0000, idx} : 48'h0;
    @(posedge clk);
    cmd_valid <= 1'b0;
    // Code and count are stale once taken; flip them so nothing leans on old values
    cmd_code <= ~code;
    cmd_count <= ~idx;
  endtask
endmodule // srer_host
`default_nettype wire

//--- sim/tb_srer_cmd_core.sv
`timescale 1ns/10ps
`default_nettype none
module tb_srer_cmd_core;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  wire cmd_valid, done, sense_avail, irq;
  wire [7:0] cmd_code, out_error, out_status;
  wire [15:0] cmd_feature, cmd_count, out_count;
  wire [47:0] cmd_lba, out_lba;
  wire [31:0] reg_rdata;
  int num_errors = 0;
  int checks = 0;
  always #25 clk = ~clk;
  srer_host u_host (.clk(clk), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .cmd_feature(cmd_feature), .cmd_count(cmd_count), .cmd_lba(cmd_lba));
  srer_cmd_core #(.NUM_ELEM(8)) u_dut (.clk(clk), .reset(reset), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .cmd_feature(cmd_feature), .cmd_count(cmd_count), .cmd_lba(cmd_lba),
    .done(done), .out_error(out_error), .out_count(out_count), .out_lba(out_lba),
    .out_status(out_status), .sense_avail(sense_avail), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [47:0] exp, input logic [47:0] got);
    checks++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      num_errors++;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk("reg_rdata", {16'h0, exp}, {16'h0, reg_rdata});
  endtask
  task automatic cmd(input logic [7:0] c, input logic [15:0] n, input logic [7:0] e,
    input logic [7:0] s, input logic [15:0] cnt, input logic [47:0] l);
    u_host.issue(c, n);
    #1;
    chk("done", 48'h1, {47'h0, done});
    chk("out_error", {40'h0, e}, {40'h0, out_error});
    chk("out_status", {40'h0, s}, {40'h0, out_status});
    chk("out_count", {32'h0, cnt}, {32'h0, out_count});
    chk("out_lba", l, out_lba);
  endtask
  task automatic close_out();
    if (num_errors == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #100000;
    num_errors++;
    close_out();
  end
  initial begin
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    cmd(8'h0B, 16'h0, 8'h00, 8'h00, 16'h0, 48'h0);
    rd(srer_pkg::REG_CTRL, 32'h0);
    rd(srer_pkg::REG_INT_MASK, 32'h0);
    rd(8'h20, 32'h0);
    // Two posted events: only the later one may come back
    wr(srer_pkg::REG_SENSE, 32'h0003_1122);
    wr(srer_pkg::REG_SENSE, 32'h0004_3344);
    #1;
    chk("sense_avail", 48'h1, {47'h0, sense_avail});
    rd(srer_pkg::REG_SENSE, 32'h0114_3344);
    cmd(8'h0B, 16'h0, 8'h00, 8'h02, 16'h0, 48'h0000_0014_3344);
    cmd(8'h0B, 16'h0, 8'h00, 8'h00, 16'h0, 48'h0);
    // A successful restore throws the record away
    wr(srer_pkg::REG_SENSE, 32'h0001_0203);
    cmd(8'h7D, 16'h0, 8'h00, 8'h00, 16'h0, 48'h0);
    cmd(8'h0B, 16'h0, 8'h00, 8'h00, 16'h0, 48'h0);
    wr(srer_pkg::REG_ELEM_DEPOP, 32'h0000_000F);
    wr(srer_pkg::REG_ELEM_ALLOW, 32'h0000_0005);
    cmd(8'h7D, 16'h0, 8'h00, 8'h00, 16'h4, 48'h0000_0000_0002);
    rd(srer_pkg::REG_ELEM_DEPOP, 32'h0000_000A);
    wr(srer_pkg::REG_ELEM_ALLOW, 32'h0);
    cmd(8'h7D, 16'h0, 8'h04, 8'h03, 16'h0, 48'h0);
    cmd(8'h0B, 16'h0, 8'h00, 8'h02, 16'h0, 48'h0000_0005_2C00);
    // Only the error bit is unmasked, so done and sense bits stay quiet
    wr(srer_pkg::REG_INT_MASK, 32'h2);
    rd(srer_pkg::REG_INT_STS, 32'h7);
    chk("irq", 48'h1, {47'h0, irq});
    wr(srer_pkg::REG_INT_STS, 32'h2);
    rd(srer_pkg::REG_INT_STS, 32'h5);
    chk("irq", 48'h0, {47'h0, irq});
    // Pending activation aborts both restore and remove; the sense read back comes from the remove
    wr(srer_pkg::REG_CTRL, 32'h1);
    cmd(8'h7D, 16'h0, 8'h04, 8'h03, 16'h0, 48'h0);
    cmd(8'h7C, 16'h0, 8'h04, 8'h03, 16'h0, 48'h0);
    cmd(8'h0B, 16'h0, 8'h00, 8'h02, 16'h0, 48'h0000_0002_0426);
    wr(srer_pkg::REG_CTRL, 32'h0);
    cmd(8'h7C, 16'h2, 8'h00, 8'h00, 16'h0, 48'h0);
    rd(srer_pkg::REG_ELEM_DEPOP, 32'h0000_000E);
    // Other failure causes each leave their own current sense code
    cmd(8'hE5, 16'h0, 8'h04, 8'h03, 16'h0, 48'h0);
    cmd(8'h0B, 16'h0, 8'h00, 8'h02, 16'h0, 48'h0000_0005_2000);
    cmd(8'h7C, 16'h8, 8'h04, 8'h03, 16'h0, 48'h0);
    cmd(8'h0B, 16'h0, 8'h00, 8'h02, 16'h0, 48'h0000_0005_2400);
    // Reading the queued error log keeps the record, any other log does not
    wr(srer_pkg::REG_SENSE, 32'h0006_2900);
    cmd(8'h47, 16'h10, 8'h00, 8'h02, 16'h0, 48'h0);
    cmd(8'h0B, 16'h0, 8'h00, 8'h02, 16'h0, 48'h0000_0016_2900);
    wr(srer_pkg::REG_SENSE, 32'h0006_2900);
    cmd(8'h2F, 16'h3, 8'h00, 8'h00, 16'h0, 48'h0);
    cmd(8'h0B, 16'h0, 8'h00, 8'h00, 16'h0, 48'h0);
    // A reset in mid-run throws the record away as well
    wr(srer_pkg::REG_SENSE, 32'h0001_0203);
    @(posedge clk);
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    #1;
    chk("sense_avail", 48'h0, {47'h0, sense_avail});
    cmd(8'h0B, 16'h0, 8'h00, 8'h00, 16'h0, 48'h0);
    close_out();
  end
endmodule // tb_srer_cmd_core
`default_nettype wire
